//--- common/err_xfer_pkg.sv
package err_xfer_pkg;
    localparam int WORD_W = 6;
    localparam int ADDR_W = 6;
    // APB byte addresses
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS = 8'h0C;
    localparam logic [7:0] ADDR_OFS = 8'h10;
    localparam logic [7:0] PC_OFS = 8'h14;
    localparam logic [7:0] XREG_OFS = 8'h18;
    localparam logic [7:0] OPREG_OFS = 8'h1C;
    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int CTRL_REPEAT_BIT = 2;
    localparam int CTRL_JSTOP_BIT = 3;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_SEL_LSB = 6;
    // Status bits (sticky)
    localparam int ST_ADD_BIT = 0;
    localparam int ST_DIV_BIT = 1;
    localparam int ST_INS_BIT = 2;
    localparam int ST_DONE_BIT = 3;
    localparam int ST_JSTOP_BIT = 4;
    localparam int ST_W = 5;
    localparam logic [4:0] MASK_RESET = 5'h00;
    localparam logic [5:0] OP_EXT_LOAD = 6'h14;
    localparam logic [5:0] OP_EXT_UNLOAD = 6'h16;
    localparam logic [5:0] OP_ODD_JUMP = 6'h0B;
    localparam logic [5:0] OP_FILL_SEQ = 6'h38;
    localparam logic [5:0] OP_ILL_LO_MAX = 6'h07;
    localparam logic [5:0] OP_ILL_HI_MIN = 6'h18;
    localparam logic [5:0] OP_ILL_HI_MAX = 6'h1F;
    localparam logic signed [7:0] RANGE_MAX = 8'sh1F;
    localparam logic signed [7:0] RANGE_MIN = -8'sh1F;
    typedef enum logic [1:0] {MODE_INSTR, MODE_PROGRAM, MODE_STEP, MODE_DIST} mode_t;
    typedef enum logic [1:0] {SEL_NO_BYPASS, SEL_OVF_IGNORE, SEL_FULL_BYPASS, SEL_RSVD} sel_t;
endpackage : err_xfer_pkg

//--- core/error_classifier.sv
`timescale 1ns/1ns
`default_nettype none
module error_classifier
(
    input wire logic add_valid,
    input wire logic signed [7:0] add_sum,
    input wire logic div_valid,
    input wire logic signed [7:0] div_quot,
    input wire logic op_valid,
    input wire logic [5:0] opcode,
    input wire logic [1:0] sel,
    output logic add_err,
    output logic div_err,
    output logic ins_err,
    output logic must_halt
);
    always_comb
    begin
        add_err = add_valid && (add_sum > err_xfer_pkg::RANGE_MAX
            || add_sum < err_xfer_pkg::RANGE_MIN);
        div_err = div_valid && (div_quot > err_xfer_pkg::RANGE_MAX
            || div_quot < err_xfer_pkg::RANGE_MIN);
        ins_err = op_valid && (opcode <= err_xfer_pkg::OP_ILL_LO_MAX
            || (opcode >= err_xfer_pkg::OP_ILL_HI_MIN
            && opcode <= err_xfer_pkg::OP_ILL_HI_MAX));
        unique case (sel)
            2'd0: must_halt = add_err || div_err || ins_err;
            2'd1: must_halt = div_err || ins_err;
            default: must_halt = 1'b0;
        endcase
    end
endmodule : error_classifier
`default_nettype wire

//--- core/error_stop_and_block_transfer.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - No-bypass position: any error lights its lamp and halts.
// - Full bypass: every error lights its lamp, execution continues.
// - Addition result beyond plus or minus 31 flags add overflow.
// - Overflow-ignore position: continue on add overflow, halt on others.
// - Quotient magnitude beyond 31 flags divide overflow; halts in no-bypass and overflow-ignore positions only.
// - Counter preset to words minus one; transfer ends when used up.
// - After last word: halt in instruction mode, run from PC in program mode.
// - Repeat on with fill op: re-execute continually until stop.
// - Fill repetition writes exchange value into every location in turn.
// - Jump-stop on: halt just before unconditional odd jump.
// - Program mode after clear: start runs from loaded PC.
// - Op codes 00-07 and 30-37 octal raise instruction error.
module error_stop_and_block_transfer
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic add_valid,
    input wire logic signed [7:0] add_sum,
    input wire logic div_valid,
    input wire logic signed [7:0] div_quot,
    input wire logic op_valid,
    input wire logic [5:0] opcode,
    input wire logic [5:0] mem_rdata,
    output logic mem_we,
    output logic [5:0] mem_addr,
    output logic [5:0] mem_wdata,
    output logic xfer_strobe,
    input wire logic ext_ready,
    input wire logic [5:0] ext_in,
    output logic [5:0] ext_out,
    output logic running,
    output logic add_lamp,
    output logic div_lamp,
    output logic ins_lamp,
    output logic irq
);
    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_FILL, ST_RUN} state_t;

    state_t state_reg;
    logic [7:0] ctrl_reg;
    logic [4:0] status_reg;
    logic [4:0] mask_reg;
    logic [5:0] count_reg;
    logic [5:0] addr_reg;
    logic [5:0] pc_reg;
    logic [5:0] xreg_reg;
    logic [5:0] op_reg;
    logic [5:0] ext_out_reg;
    logic [5:0] ext_s1_reg;
    logic [5:0] ext_s2_reg;
    logic rdy_s1_reg;
    logic rdy_s2_reg;
    logic rdy_d_reg;
    logic add_err;
    logic div_err;
    logic ins_err;
    logic must_halt;
    logic wr;
    logic rd_ok;
    logic start_p;
    logic stop_p;
    logic step;
    logic last_word;
    logic jump_hit;
    logic [4:0] events;
    logic [1:0] mode;
    logic [1:0] selector;

    error_classifier u_cls
    (
        .add_valid(add_valid && state_reg == ST_RUN),
        .add_sum(add_sum),
        .div_valid(div_valid && state_reg == ST_RUN),
        .div_quot(div_quot),
        .op_valid(op_valid && state_reg == ST_RUN),
        .opcode(opcode),
        .sel(selector),
        .add_err(add_err),
        .div_err(div_err),
        .ins_err(ins_err),
        .must_halt(must_halt)
    );

    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign mode = ctrl_reg[err_xfer_pkg::CTRL_MODE_LSB +: 2];
    assign selector = ctrl_reg[err_xfer_pkg::CTRL_SEL_LSB +: 2];
    assign start_p = wr && paddr == err_xfer_pkg::CTRL_OFS
        && pwdata[err_xfer_pkg::CTRL_START_BIT];
    assign stop_p = wr && paddr == err_xfer_pkg::CTRL_OFS
        && pwdata[err_xfer_pkg::CTRL_STOP_BIT];
    // Panel ready line is a pin: two flops, then a rising-edge detect
    assign step = rdy_s2_reg && !rdy_d_reg;
    assign last_word = count_reg == 6'h00;
    assign jump_hit = op_valid && state_reg == ST_RUN
        && ctrl_reg[err_xfer_pkg::CTRL_JSTOP_BIT] && opcode == err_xfer_pkg::OP_ODD_JUMP;
    assign events = {jump_hit, state_reg == ST_XFER && step && last_word,
        ins_err, div_err, add_err};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdy_s1_reg <= 1'b0;
            rdy_s2_reg <= 1'b0;
            rdy_d_reg <= 1'b0;
            ext_s1_reg <= 6'h00;
            ext_s2_reg <= 6'h00;
        end
        else
        begin
            rdy_s1_reg <= ext_ready;
            rdy_s2_reg <= rdy_s1_reg;
            rdy_d_reg <= rdy_s2_reg;
            ext_s1_reg <= ext_in;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= 8'h00;
            mask_reg <= err_xfer_pkg::MASK_RESET;
            pc_reg <= 6'h00;
            xreg_reg <= 6'h00;
            op_reg <= 6'h00;
        end
        else if (wr)
        begin
            unique case (paddr)
                err_xfer_pkg::CTRL_OFS: ctrl_reg <= {pwdata[7:2], 2'b00};
                err_xfer_pkg::MASK_OFS: mask_reg <= pwdata[4:0];
                err_xfer_pkg::PC_OFS: pc_reg <= pwdata[5:0];
                err_xfer_pkg::XREG_OFS: xreg_reg <= pwdata[5:0];
                err_xfer_pkg::OPREG_OFS: op_reg <= pwdata[5:0];
                default: ;
            endcase
        end
    end

    // Sticky status; hardware set beats software clear; reset is panel clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_reg <= 5'h00;
        else if (wr && paddr == err_xfer_pkg::STATUS_OFS)
            status_reg <= (status_reg & ~pwdata[4:0]) | events;
        else
            status_reg <= status_reg | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_IDLE;
            count_reg <= 6'h00;
            addr_reg <= 6'h00;
        end
        else
        begin
            if (wr && paddr == err_xfer_pkg::COUNT_OFS && state_reg == ST_IDLE)
                count_reg <= pwdata[5:0];
            if (wr && paddr == err_xfer_pkg::ADDR_OFS && state_reg == ST_IDLE)
                addr_reg <= pwdata[5:0];
            unique case (state_reg)
                ST_IDLE:
                begin
                    // Switches written together with start apply to that start
                    if (start_p)
                    begin
                        if (op_reg == err_xfer_pkg::OP_FILL_SEQ
                            && pwdata[err_xfer_pkg::CTRL_REPEAT_BIT])
                            state_reg <= ST_FILL;
                        else if (op_reg == err_xfer_pkg::OP_EXT_LOAD
                            || op_reg == err_xfer_pkg::OP_EXT_UNLOAD)
                            state_reg <= ST_XFER;
                        else if (pwdata[err_xfer_pkg::CTRL_MODE_LSB +: 2] == 2'd1)
                            state_reg <= ST_RUN;
                    end
                end
                ST_XFER:
                begin
                    if (stop_p)
                        state_reg <= ST_IDLE;
                    else if (step)
                    begin
                        addr_reg <= addr_reg + 6'h01;
                        if (last_word)
                            state_reg <= (mode == 2'd1) ? ST_RUN : ST_IDLE;
                        else
                            count_reg <= count_reg - 6'h01;
                    end
                end
                ST_FILL:
                begin
                    addr_reg <= addr_reg + 6'h01;
                    if (stop_p)
                        state_reg <= ST_IDLE;
                end
                ST_RUN:
                begin
                    if (stop_p || must_halt || jump_hit)
                        state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_out_reg <= 6'h00;
        else if (state_reg == ST_XFER && step && op_reg == err_xfer_pkg::OP_EXT_UNLOAD)
            ext_out_reg <= mem_rdata;
    end

    always_comb
    begin
        mem_addr = addr_reg;
        mem_we = 1'b0;
        mem_wdata = xreg_reg;
        if (state_reg == ST_FILL)
            mem_we = 1'b1;
        else if (state_reg == ST_XFER && step && op_reg == err_xfer_pkg::OP_EXT_LOAD)
        begin
            mem_we = 1'b1;
            mem_wdata = ext_s2_reg;
        end
    end

    assign xfer_strobe = state_reg == ST_XFER && step;
    assign ext_out = ext_out_reg;
    assign running = state_reg != ST_IDLE;
    assign add_lamp = status_reg[err_xfer_pkg::ST_ADD_BIT];
    assign div_lamp = status_reg[err_xfer_pkg::ST_DIV_BIT];
    assign ins_lamp = status_reg[err_xfer_pkg::ST_INS_BIT];
    assign irq = |(status_reg & mask_reg);
    assign rd_ok = 1'b1;
    assign pslverr = 1'b0;

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite && rd_ok)
        begin
            unique case (paddr)
                err_xfer_pkg::CTRL_OFS: prdata = {24'h000000, ctrl_reg};
                err_xfer_pkg::STATUS_OFS: prdata = {27'h0000000, status_reg};
                err_xfer_pkg::MASK_OFS: prdata = {27'h0000000, mask_reg};
                err_xfer_pkg::COUNT_OFS: prdata = {26'h0000000, count_reg};
                err_xfer_pkg::ADDR_OFS: prdata = {26'h0000000, addr_reg};
                err_xfer_pkg::PC_OFS: prdata = {26'h0000000, pc_reg};
                err_xfer_pkg::XREG_OFS: prdata = {26'h0000000, xreg_reg};
                err_xfer_pkg::OPREG_OFS: prdata = {26'h0000000, op_reg};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    property p_halt_no_bypass;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_RUN && add_err && selector == 2'd0 && !stop_p)
            |=> (state_reg == ST_IDLE && add_lamp);
    endproperty
    a_halt_no_bypass: assert property (p_halt_no_bypass) else $error("no halt on error");

    property p_full_bypass;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_RUN && ins_err && selector == 2'd2 && !stop_p && !jump_hit)
            |=> (state_reg == ST_RUN && ins_lamp);
    endproperty
    a_full_bypass: assert property (p_full_bypass) else $error("bypass halted");

    property p_add_range;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_RUN && add_valid && add_sum == 8'sh20) |=> add_lamp;
    endproperty
    a_add_range: assert property (p_add_range) else $error("add overflow missed");

    property p_ovf_ignore;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_RUN && selector == 2'd1 && add_err && !div_err
            && !ins_err && !stop_p && !jump_hit) |=> state_reg == ST_RUN;
    endproperty
    a_ovf_ignore: assert property (p_ovf_ignore) else $error("halted on add");

    property p_div_range;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_RUN && div_valid && div_quot == -8'sh20) |=> div_lamp;
    endproperty
    a_div_range: assert property (p_div_range) else $error("divide overflow missed");

    property p_count_end;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_XFER && step && last_word && !stop_p && mode == 2'd0)
            |=> state_reg == ST_IDLE;
    endproperty
    a_count_end: assert property (p_count_end) else $error("transfer overran");

    property p_fill_walk;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_FILL && !stop_p) |=> mem_addr == $past(addr_reg) + 6'h01;
    endproperty
    a_fill_walk: assert property (p_fill_walk) else $error("fill address stuck");

    property p_jump_stop;
        @(posedge pclk) disable iff (!presetn)
        jump_hit |=> (state_reg == ST_IDLE && status_reg[err_xfer_pkg::ST_JSTOP_BIT]);
    endproperty
    a_jump_stop: assert property (p_jump_stop) else $error("jump stop missed");

    property p_lamp_hold;
        @(posedge pclk) disable iff (!presetn)
        (add_lamp && !(wr && paddr == err_xfer_pkg::STATUS_OFS
            && pwdata[err_xfer_pkg::ST_ADD_BIT])) |=> add_lamp;
    endproperty
    a_lamp_hold: assert property (p_lamp_hold) else $error("lamp dropped");
endmodule : error_stop_and_block_transfer
`default_nettype wire

//--- tb/panel_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module panel_side_model
(
    input wire logic pclk,
    input wire logic mem_we,
    input wire logic [5:0] mem_addr,
    input wire logic [5:0] mem_wdata,
    output logic [5:0] mem_rdata,
    output logic ext_ready,
    output logic [5:0] ext_in
);
    logic [5:0] mem [64];

    initial
    begin
        for (int i = 0; i < 64; i++)
        begin
            mem[i] = 6'(i) ^ 6'h3F;
        end
        ext_ready = 1'b0;
        ext_in = 6'h3F;
    end

    always @(posedge pclk)
    begin
        if (mem_we)
        begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    assign mem_rdata = mem[mem_addr];

    // One word step; the word is set up first and inverted once the step is over
    task automatic step(input logic [5:0] w, input int hold);
        @(posedge pclk);
        ext_in <= w;
        repeat (3) @(posedge pclk);
        ext_ready <= 1'b1;
        repeat (hold) @(posedge pclk);
        ext_ready <= 1'b0;
        repeat (5) @(posedge pclk);
        ext_in <= ~w;
    endtask : step
endmodule : panel_side_model
`default_nettype wire

//--- tb/error_stop_and_block_transfer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module error_stop_and_block_transfer_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic add_valid = 1'b0, div_valid = 1'b0, op_valid = 1'b0;
    logic signed [7:0] add_sum = 8'sh00, div_quot = 8'sh00;
    logic [5:0] opcode = 6'h20;
    logic [31:0] prdata;
    logic pready, pslverr, mem_we, xfer_strobe, running, add_lamp, div_lamp, ins_lamp, irq;
    logic ext_ready;
    logic [5:0] mem_rdata, mem_addr, mem_wdata, ext_in, ext_out;
    int err_count = 0;
    int comparisons = 0;
    int strobes = 0;
    logic [1:0] c_kind [13] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2};
    logic [7:0] c_val [13] = '{8'h1F, 8'hE1, 8'h20, 8'hE0, 8'h1F, 8'hE1, 8'hE0,
        8'h07, 8'h08, 8'h17, 8'h18, 8'h1F, 8'h00};
    logic c_flag [13] = '{0, 0, 1, 1, 0, 0, 1, 1, 0, 0, 1, 1, 1};

    always #50 pclk = ~pclk;

    // Counts word steps the block reports on its transfer strobe
    always @(posedge pclk)
    begin
        if (xfer_strobe === 1'b1)
        begin
            strobes <= strobes + 1;
        end
    end

    error_stop_and_block_transfer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .add_valid(add_valid), .add_sum(add_sum),
        .div_valid(div_valid), .div_quot(div_quot), .op_valid(op_valid), .opcode(opcode),
        .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .xfer_strobe(xfer_strobe), .ext_ready(ext_ready), .ext_in(ext_in), .ext_out(ext_out),
        .running(running), .add_lamp(add_lamp), .div_lamp(div_lamp), .ins_lamp(ins_lamp),
        .irq(irq));

    panel_side_model far (.pclk(pclk), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .ext_ready(ext_ready), .ext_in(ext_in));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        r = prdata;
        if (n >= 20)
        begin
            err_count++;
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(a, 1'b1, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(a, 1'b0, 32'h0, r);
        chk(r, e);
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : tick

    function automatic logic [31:0] ctrl(input logic st, input logic sp, input logic rep,
        input logic js, input logic [1:0] mode, input logic [1:0] sel);
        return {24'h0, sel, mode, js, rep, sp, st};
    endfunction : ctrl

    task automatic test_reset;
        rd_chk(err_xfer_pkg::CTRL_OFS, 32'h0);
        rd_chk(err_xfer_pkg::STATUS_OFS, 32'h0);
        rd_chk(err_xfer_pkg::MASK_OFS, 32'(err_xfer_pkg::MASK_RESET));
        wr(8'h40, 32'h3F);
        rd_chk(8'h40, 32'h0);
        chk(32'(running), 32'h0);
        chk(32'(pslverr), 32'h0);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_errors;
        logic [1:0] k;
        logic f;
        logic halt;
        wr(err_xfer_pkg::OPREG_OFS, 32'h20);
        for (int s = 0; s < 4; s++)
        begin
            for (int i = 0; i < 13; i++)
            begin
                k = c_kind[i];
                f = c_flag[i];
                halt = f && (s == 0 || (s == 1 && k != 2'd0));
                wr(err_xfer_pkg::MASK_OFS, 32'h1F);
                wr(err_xfer_pkg::CTRL_OFS, ctrl(1, 0, 0, 0, 2'd1, 2'(s)));
                tick(2);
                chk(32'(running), 32'h1);
                @(posedge pclk);
                add_valid <= (k == 2'd0);
                div_valid <= (k == 2'd1);
                op_valid <= (k == 2'd2);
                add_sum <= c_val[i];
                div_quot <= c_val[i];
                opcode <= c_val[i][5:0];
                @(posedge pclk);
                add_valid <= 1'b0;
                div_valid <= 1'b0;
                op_valid <= 1'b0;
                tick(6);
                chk(32'(running), 32'(!halt));
                chk(32'({ins_lamp, div_lamp, add_lamp}), 32'(f) << k);
                chk(32'(irq), 32'(f));
                rd_chk(err_xfer_pkg::STATUS_OFS, 32'(f) << k);
                wr(err_xfer_pkg::MASK_OFS, 32'h0);
                tick(1);
                chk(32'(irq), 32'h0);
                wr(err_xfer_pkg::STATUS_OFS, 32'h7);
                tick(1);
                chk(32'({ins_lamp, div_lamp, add_lamp}), 32'h0);
                wr(err_xfer_pkg::CTRL_OFS, ctrl(0, 1, 0, 0, 2'd1, 2'(s)));
            end
        end
        $display("test_errors done");
    endtask : test_errors

    task automatic test_jump;
        for (int j = 0; j < 2; j++)
        begin
            wr(err_xfer_pkg::CTRL_OFS, ctrl(1, 0, 0, 1'(j), 2'd1, 2'd0));
            tick(2);
            @(posedge pclk);
            op_valid <= 1'b1;
            opcode <= err_xfer_pkg::OP_ODD_JUMP;
            @(posedge pclk);
            op_valid <= 1'b0;
            tick(3);
            chk(32'(running), 32'(j == 0));
            rd_chk(err_xfer_pkg::STATUS_OFS, 32'(j) << err_xfer_pkg::ST_JSTOP_BIT);
            wr(err_xfer_pkg::STATUS_OFS, 32'h1F);
            wr(err_xfer_pkg::CTRL_OFS, ctrl(0, 1, 0, 0, 2'd1, 2'd0));
        end
        $display("test_jump done");
    endtask : test_jump

    task automatic test_transfer;
        logic [5:0] w [3] = '{6'h2A, 6'h00, 6'h15};
        wr(err_xfer_pkg::OPREG_OFS, 32'h10);
        wr(err_xfer_pkg::OPREG_OFS, 32'(err_xfer_pkg::OP_EXT_LOAD));
        wr(err_xfer_pkg::COUNT_OFS, 32'h2);
        wr(err_xfer_pkg::ADDR_OFS, 32'h5);
        wr(err_xfer_pkg::CTRL_OFS, ctrl(1, 0, 0, 0, 2'd0, 2'd0));
        tick(2);
        far.step(w[0], 1);
        far.step(w[1], 6);
        far.step(w[2], 3);
        tick(4);
        chk(32'(running), 32'h0);
        rd_chk(err_xfer_pkg::STATUS_OFS, 32'h8);
        far.step(6'h33, 3);
        tick(4);
        for (int i = 0; i < 3; i++)
        begin
            chk(32'(far.mem[5 + i]), 32'(w[i]));
        end
        chk(32'(far.mem[8]), 32'h37);
        chk(32'(strobes), 32'h3);
        rd_chk(err_xfer_pkg::ADDR_OFS, 32'h8);
        wr(err_xfer_pkg::STATUS_OFS, 32'h1F);
        wr(err_xfer_pkg::OPREG_OFS, 32'h12);
        wr(err_xfer_pkg::OPREG_OFS, 32'(err_xfer_pkg::OP_EXT_UNLOAD));
        wr(err_xfer_pkg::COUNT_OFS, 32'h1);
        wr(err_xfer_pkg::ADDR_OFS, 32'h5);
        wr(err_xfer_pkg::PC_OFS, 32'h20);
        rd_chk(err_xfer_pkg::PC_OFS, 32'h20);
        wr(err_xfer_pkg::CTRL_OFS, ctrl(1, 0, 0, 0, 2'd1, 2'd0));
        tick(2);
        for (int i = 0; i < 2; i++)
        begin
            far.step(6'h3F, 2 + 3 * i);
            tick(2);
            chk(32'(ext_out), 32'(w[i]));
        end
        chk(32'(running), 32'h1);
        chk(32'(strobes), 32'h5);
        wr(err_xfer_pkg::CTRL_OFS, ctrl(0, 1, 0, 0, 2'd1, 2'd0));
        wr(err_xfer_pkg::STATUS_OFS, 32'h1F);
        $display("test_transfer done");
    endtask : test_transfer

    task automatic test_clear;
        wr(err_xfer_pkg::OPREG_OFS, 32'h20);
        wr(err_xfer_pkg::CTRL_OFS, ctrl(1, 0, 0, 0, 2'd1, 2'd2));
        @(posedge pclk);
        add_valid <= 1'b1;
        add_sum <= 8'sh20;
        @(posedge pclk);
        add_valid <= 1'b0;
        tick(2);
        chk(32'({running, add_lamp}), 32'h3);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        chk(32'({running, add_lamp}), 32'h0);
        $display("test_clear done");
    endtask : test_clear

    task automatic test_fill;
        logic [5:0] v;
        int bad;
        for (int n = 0; n < 2; n++)
        begin
            v = (n == 0) ? 6'h2A : 6'h00;
            wr(err_xfer_pkg::XREG_OFS, 32'(v));
            wr(err_xfer_pkg::OPREG_OFS, 32'(err_xfer_pkg::OP_FILL_SEQ));
            wr(err_xfer_pkg::CTRL_OFS, ctrl(1, 0, 1, 0, 2'd0, 2'd0));
            tick(80);
            wr(err_xfer_pkg::CTRL_OFS, ctrl(0, 1, 1, 0, 2'd0, 2'd0));
            tick(2);
            bad = 0;
            for (int a = 0; a < 64; a++)
            begin
                bad += (far.mem[a] !== v) ? 1 : 0;
            end
            chk(32'(bad), 32'h0);
            wr(err_xfer_pkg::XREG_OFS, 32'h15);
            tick(10);
            chk(32'(far.mem[0]), 32'(v));
        end
        $display("test_fill done");
    endtask : test_fill

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_errors();
        test_jump();
        test_transfer();
        test_clear();
        test_fill();
        tally_and_finish();
    end
endmodule : error_stop_and_block_transfer_tb_top
`default_nettype wire
